//--- rtl/spl_limit.sv
// Software position limit supervisor with its object registers.
`timescale 1ns/1ps
module spl_limit (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire spl_pkg::spl_obj_req_t i_obj,
  output logic [31:0]            o_obj_rdata,
  output logic                   o_obj_rvalid,
  input  wire spl_pkg::spl_pos_t i_pos,
  input  wire logic [3:0]        i_op_mode,
  input  wire logic [2:0]        i_csm_state,
  input  wire logic              i_abs_encoder,
  input  wire logic              i_homing_busy,
  input  wire logic              i_homing_done,
  input  wire logic              i_servo_on,
  input  wire logic [15:0]       i_torque_offset_obj,
  input  wire logic [2:0]        i_qs_option,
  output logic [31:0]            o_max_accel_eff,
  output logic [15:0]            o_torque_offset_int,
  output logic                   o_status_limit_active,
  output logic                   o_quick_stop_req,
  output logic                   o_block_pos,
  output logic                   o_block_neg,
  output logic                   o_improper_op_fault
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // A step bigger than a quarter turn of the 32-bit range means the value wrapped.
  function automatic logic wrapped(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] d;
    d = a - b;
    wrapped = ($signed(d) > $signed(spl_pkg::WORD_QUARTER)) ||
              ($signed(d) < -$signed(spl_pkg::WORD_QUARTER));
  endfunction : wrapped

  function automatic logic in_range(input logic [31:0] p, input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = ($signed(p) > $signed(lo)) && ($signed(p) < $signed(hi));
  endfunction : in_range

  spl_pkg::spl_state_t st_ff;
  spl_pkg::spl_state_t nxt_st;

  logic mode_ok;
  logic order_ok;
  logic enabled;
  logic at_neg;
  logic at_pos;
  logic wrap_hit;
  logic qs_ramp;
  logic is_lim;
  logic cyc_en;

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  // Enable terms are combinational so a mode or order change gates the blocks
  // at once, while status and quick stop still move only on a control cycle.
  always_comb begin
    mode_ok  = (i_op_mode == spl_pkg::MODE_PROFILE_POSITION) ||
               (i_op_mode == spl_pkg::MODE_INTERPOLATED_POS) ||
               (i_op_mode == spl_pkg::MODE_CYCLIC_SYNC_POS);
    order_ok = $signed(st_ff.neg_limit) < $signed(st_ff.pos_limit);
    enabled  = mode_ok && order_ok && (st_ff.coord == spl_pkg::COORD_FINAL);
    cyc_en   = i_pos.cycle;
    // Positions already carry the home offset, the same basis as the demand.
    at_neg   = $signed(i_pos.actual) <= $signed(st_ff.neg_limit) ||
               $signed(i_pos.command) <= $signed(st_ff.neg_limit);
    at_pos   = $signed(i_pos.actual) >= $signed(st_ff.pos_limit) ||
               $signed(i_pos.command) >= $signed(st_ff.pos_limit);
    wrap_hit = st_ff.hist_valid && (wrapped(i_pos.actual, st_ff.act_last) ||
               wrapped(i_pos.command, st_ff.cmd_last));
    qs_ramp  = (i_qs_option == spl_pkg::QS_OPT_RAMP_A) ||
               (i_qs_option == spl_pkg::QS_OPT_RAMP_B);
    is_lim   = i_obj.index == spl_pkg::IDX_POSITION_LIMIT;
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.rvalid = 1'b0;

    if (i_obj.wr) begin
      if (i_obj.index == spl_pkg::IDX_COMM_EXT_SETUP_3) begin
        nxt_st.ext_setup = i_obj.wdata[15:0];
      end else if (is_lim && i_obj.sub == spl_pkg::SUB_NEG_LIMIT) begin
        nxt_st.neg_limit = i_obj.wdata;
      end else if (is_lim && i_obj.sub == spl_pkg::SUB_POS_LIMIT) begin
        nxt_st.pos_limit = i_obj.wdata;
      end else if (i_obj.index == spl_pkg::IDX_MAX_ACCEL) begin
        nxt_st.max_accel = i_obj.wdata;
      end
    end
    if (i_obj.rd) begin
      nxt_st.rvalid = 1'b1;
      if (i_obj.index == spl_pkg::IDX_COMM_EXT_SETUP_3) begin
        nxt_st.rdata = {16'h0000, st_ff.ext_setup};
      end else if (is_lim && i_obj.sub == spl_pkg::SUB_ENTRY_COUNT) begin
        nxt_st.rdata = {24'h000000, spl_pkg::LIMIT_ENTRY_COUNT};
      end else if (is_lim && i_obj.sub == spl_pkg::SUB_NEG_LIMIT) begin
        nxt_st.rdata = st_ff.neg_limit;
      end else if (is_lim && i_obj.sub == spl_pkg::SUB_POS_LIMIT) begin
        nxt_st.rdata = st_ff.pos_limit;
      end else if (i_obj.index == spl_pkg::IDX_MAX_ACCEL) begin
        nxt_st.rdata = st_ff.max_accel;
      end else begin
        nxt_st.rdata = spl_pkg::WORD_ZERO;
      end
    end

    // Torque offset internal value while the servo is off.
    if (i_servo_on || st_ff.ext_setup[spl_pkg::TQ_OFFSET_KEEP_BIT]) begin
      nxt_st.tq_offset = i_torque_offset_obj;
    end else begin
      nxt_st.tq_offset = 16'h0000;
    end

    // Coordinate qualification.
    nxt_st.csm_last = spl_pkg::spl_csm_t'(i_csm_state);
    if (i_homing_busy) begin
      nxt_st.coord = spl_pkg::COORD_HOMING;
    end else if (i_homing_done) begin
      nxt_st.coord = spl_pkg::COORD_FINAL;
    end else if (i_abs_encoder) begin
      if (st_ff.coord != spl_pkg::COORD_HOMING) begin
        nxt_st.coord = (i_csm_state >= spl_pkg::CSM_PRE_OP) ?
                       spl_pkg::COORD_FINAL : spl_pkg::COORD_UNSET;
      end
    end else if (st_ff.csm_last == spl_pkg::CSM_INIT &&
                 i_csm_state == spl_pkg::CSM_PRE_OP) begin
      nxt_st.coord = spl_pkg::COORD_UNSET;
    end

    // Once per control cycle: wrap, reach and status evaluation.
    if (cyc_en) begin
      nxt_st.act_last   = i_pos.actual;
      nxt_st.cmd_last   = i_pos.command;
      nxt_st.hist_valid = 1'b1;
      if (enabled && wrap_hit) begin
        nxt_st.fault = 1'b1;
      end
      if (enabled) begin
        nxt_st.limit_active = !in_range(i_pos.actual, st_ff.neg_limit,
                                        st_ff.pos_limit);
        // In cyclic mode the request lands on the next subdivided cycle at worst.
        nxt_st.quick_stop = i_pos.moving && qs_ramp &&
                            ((at_neg && !i_pos.dir_pos) ||
                             (at_pos && i_pos.dir_pos));
      end else begin
        nxt_st.limit_active = 1'b0;
        nxt_st.quick_stop   = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // The maximum acceleration resets to zero, so the floor applies until written.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_ff <= '{ext_setup: spl_pkg::EXT_SETUP_RESET,
                 neg_limit: spl_pkg::LIMIT_RESET,
                 pos_limit: spl_pkg::LIMIT_RESET,
                 max_accel: spl_pkg::MAX_ACCEL_RESET,
                 rdata: spl_pkg::WORD_ZERO,
                 rvalid: 1'b0,
                 coord: spl_pkg::COORD_UNSET,
                 csm_last: spl_pkg::CSM_INIT,
                 act_last: spl_pkg::WORD_ZERO,
                 cmd_last: spl_pkg::WORD_ZERO,
                 hist_valid: 1'b0,
                 limit_active: 1'b0,
                 quick_stop: 1'b0,
                 fault: 1'b0,
                 tq_offset: 16'h0000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  always_comb begin
    o_obj_rdata           = st_ff.rdata;
    o_obj_rvalid          = st_ff.rvalid;
    o_max_accel_eff       = (st_ff.max_accel == spl_pkg::WORD_ZERO) ?
                            spl_pkg::MAX_ACCEL_FLOOR : st_ff.max_accel;
    o_torque_offset_int   = st_ff.tq_offset;
    o_status_limit_active = st_ff.limit_active;
    o_quick_stop_req      = st_ff.quick_stop;
    // Blocking is held with the status so the axis can only walk back inward.
    o_block_neg           = st_ff.limit_active && enabled &&
                            !($signed(i_pos.actual) > $signed(st_ff.neg_limit));
    o_block_pos           = st_ff.limit_active && enabled &&
                            !($signed(i_pos.actual) < $signed(st_ff.pos_limit));
    o_improper_op_fault   = st_ff.fault;
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_accel_floor: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_max_accel_eff != spl_pkg::WORD_ZERO) else $error("max accel effective is zero");

  a_tq_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_servo_on && !st_ff.ext_setup[spl_pkg::TQ_OFFSET_KEEP_BIT]
    |=> o_torque_offset_int == 16'h0000)
    else $error("torque offset not cleared at servo off");

  a_entry_count: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_obj.rd && is_lim && i_obj.sub == spl_pkg::SUB_ENTRY_COUNT |=>
    o_obj_rvalid && o_obj_rdata == 32'h0000_0002) else $error("entry count not two");

  a_mode_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    cyc_en && !mode_ok |=> !o_status_limit_active && !o_quick_stop_req)
    else $error("limit active outside position modes");

  a_order_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    cyc_en && !order_ok |=> !o_status_limit_active) else $error("limit active with bad order");

  a_homing_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_homing_busy ##1 cyc_en |=> !o_status_limit_active)
    else $error("limit active during homing");

  a_init_pre_operational_state: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_abs_encoder && !i_homing_busy && !i_homing_done &&
    st_ff.csm_last == spl_pkg::CSM_INIT && i_csm_state == spl_pkg::CSM_PRE_OP
    |=> st_ff.coord == spl_pkg::COORD_UNSET) else $error("coordinate kept after init to pre-op");

  a_wrap_fault: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    cyc_en && enabled && wrap_hit |=> o_improper_op_fault) else $error("wrap fault missed");

  a_status_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    cyc_en && enabled && !in_range(i_pos.actual, st_ff.neg_limit, st_ff.pos_limit)
    |=> o_status_limit_active) else $error("status bit not set out of range");

  a_qs_start: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    cyc_en && enabled && i_pos.moving && qs_ramp && at_pos && i_pos.dir_pos
    |=> o_quick_stop_req) else $error("quick stop not started at limit");

  // ---------------------------------------------------------------------------
  // Further checks
  // ---------------------------------------------------------------------------
  a_qs_neg_side: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    cyc_en && enabled && i_pos.moving && qs_ramp && at_neg && !i_pos.dir_pos
    |=> o_quick_stop_req)
    else $error("quick stop not started at negative limit");

  a_qs_option: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    cyc_en && !qs_ramp
    |=> !o_quick_stop_req)
    else $error("quick stop without ramp option");

  a_cycle_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !cyc_en
    |=> $stable(o_status_limit_active) && $stable(o_quick_stop_req))
    else $error("status moved without control cycle");

  a_block_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !o_status_limit_active
    |-> !o_block_pos && !o_block_neg)
    else $error("motion blocked while inside range");

  a_block_one_way: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_block_pos
    |-> !o_block_neg)
    else $error("both directions blocked");

  a_fault_sticky: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_improper_op_fault
    |=> o_improper_op_fault)
    else $error("fault dropped before reset");

  a_accel_pass: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st_ff.max_accel != spl_pkg::WORD_ZERO
    |-> o_max_accel_eff == st_ff.max_accel)
    else $error("nonzero max accel altered");

  a_rvalid_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_obj.rd
    |=> !o_obj_rvalid)
    else $error("read valid without read");

  a_neg_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_obj.wr && is_lim && i_obj.sub == spl_pkg::SUB_NEG_LIMIT
    |=> st_ff.neg_limit == $past(i_obj.wdata))
    else $error("negative limit write lost");

  a_pos_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_obj.wr && is_lim && i_obj.sub == spl_pkg::SUB_POS_LIMIT
    |=> st_ff.pos_limit == $past(i_obj.wdata))
    else $error("positive limit write lost");

  a_tq_follow: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_servo_on
    |=> o_torque_offset_int == $past(i_torque_offset_obj))
    else $error("torque offset not following at servo on");

  a_abs_final: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_abs_encoder && !i_homing_busy && !i_homing_done &&
    st_ff.coord != spl_pkg::COORD_HOMING && i_csm_state >= spl_pkg::CSM_PRE_OP
    |=> st_ff.coord == spl_pkg::COORD_FINAL)
    else $error("absolute coordinate not final at pre-op");

  a_homed_final: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_homing_busy && i_homing_done
    |=> st_ff.coord == spl_pkg::COORD_FINAL)
    else $error("coordinate not final after homing");

  // Coverage of the main scenarios.
  c_limit_hit: cover property (@(posedge i_sys_clk) o_quick_stop_req);
  c_fault: cover property (@(posedge i_sys_clk) o_improper_op_fault);
  c_block: cover property (@(posedge i_sys_clk) o_block_pos || o_block_neg);
  c_status: cover property (@(posedge i_sys_clk) o_status_limit_active);
  c_homed: cover property (@(posedge i_sys_clk) i_homing_done ##1 st_ff.coord == spl_pkg::COORD_FINAL);

endmodule : spl_limit

//--- rtl/spl_pkg.sv
// Package of constants and carrier types for the software position limit supervisor.
package spl_pkg;

  // ---------------------------------------------------------------------------
  // Object map
  // ---------------------------------------------------------------------------
  localparam logic [15:0] IDX_COMM_EXT_SETUP_3 = 16'h3724;
  localparam logic [15:0] IDX_POSITION_LIMIT   = 16'h607D;
  localparam logic [15:0] IDX_MAX_ACCEL        = 16'h60C5;
  localparam logic [7:0]  SUB_ENTRY_COUNT      = 8'h00;
  localparam logic [7:0]  SUB_NEG_LIMIT        = 8'h01;
  localparam logic [7:0]  SUB_POS_LIMIT        = 8'h02;
  localparam logic [7:0]  LIMIT_ENTRY_COUNT    = 8'h02;

  // ---------------------------------------------------------------------------
  // Fields, reset values and codes
  // ---------------------------------------------------------------------------
  localparam int          TQ_OFFSET_KEEP_BIT   = 7;
  localparam int          STATUS_LIMIT_BIT     = 11;
  localparam logic [15:0] EXT_SETUP_RESET      = 16'h0000;
  localparam logic [31:0] LIMIT_RESET          = 32'h0000_0000;
  localparam logic [31:0] MAX_ACCEL_RESET      = 32'h0000_0000;
  localparam logic [31:0] MAX_ACCEL_FLOOR      = 32'h0000_0001;
  localparam logic [31:0] WORD_ZERO            = 32'h0000_0000;
  localparam logic [31:0] WORD_QUARTER         = 32'h4000_0000;
  localparam logic [2:0]  QS_OPT_RAMP_A        = 3'h2;
  localparam logic [2:0]  QS_OPT_RAMP_B        = 3'h6;

  // Operating modes as carried on the mode input.
  typedef enum logic [3:0] {
    MODE_PROFILE_POSITION = 4'h1,
    MODE_PROFILE_VELOCITY = 4'h3,
    MODE_HOMING           = 4'h6,
    MODE_INTERPOLATED_POS = 4'h7,
    MODE_CYCLIC_SYNC_POS  = 4'h8
  } spl_mode_t;

  // Communication state machine states.
  typedef enum logic [2:0] {
    CSM_INIT    = 3'h1,
    CSM_PRE_OP  = 3'h2,
    CSM_BOOT    = 3'h3,
    CSM_SAFE_OP = 3'h4,
    CSM_OP      = 3'h5
  } spl_csm_t;

  // Coordinate qualification state.
  typedef enum logic [1:0] {
    COORD_UNSET   = 2'b00,
    COORD_HOMING  = 2'b01,
    COORD_FINAL   = 2'b10
  } spl_coord_t;

  // Object write/read request.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } spl_obj_req_t;

  // Position samples for one control cycle.
  typedef struct packed {
    logic        cycle;
    logic [31:0] actual;
    logic [31:0] command;
    logic        moving;
    logic        dir_pos;
  } spl_pos_t;

  // All state of the supervisor.
  typedef struct packed {
    logic [15:0] ext_setup;
    logic [31:0] neg_limit;
    logic [31:0] pos_limit;
    logic [31:0] max_accel;
    logic [31:0] rdata;
    logic        rvalid;
    spl_coord_t  coord;
    spl_csm_t    csm_last;
    logic [31:0] act_last;
    logic [31:0] cmd_last;
    logic        hist_valid;
    logic        limit_active;
    logic        quick_stop;
    logic        fault;
    logic [15:0] tq_offset;
  } spl_state_t;

endpackage : spl_pkg

//--- test/spl_master_model.sv
// Fieldbus master model that issues cyclic position samples to the supervisor.
`timescale 1ns/1ps
module spl_master_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_period,
  input  wire logic [31:0] i_act,
  input  wire logic [31:0] i_cmd,
  input  wire logic        i_moving,
  input  wire logic        i_dir_pos,
  output spl_pkg::spl_pos_t o_pos
);
  // ---------------------------------------------------------------------------
  // Cycle strobe generation
  // ---------------------------------------------------------------------------
  logic [3:0] cnt_ff;

  initial o_pos = '0;

  // Samples are latched only at the strobe, so they stand still between cycles
  // exactly as a master that sends one frame per control cycle would.
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt_ff <= #1 4'h0;
      o_pos  <= #1 '0;
    end else if (cnt_ff + 4'h1 >= i_period) begin
      cnt_ff <= #1 4'h0;
      o_pos  <= #1 {1'b1, i_act, i_cmd, i_moving, i_dir_pos};
    end else begin
      cnt_ff      <= #1 cnt_ff + 4'h1;
      o_pos.cycle <= #1 1'b0;
    end
  end
endmodule : spl_master_model

//--- test/spl_limit_tb.sv
// Self-checking testbench for the software position limit supervisor.
`timescale 1ns/1ps
module spl_limit_tb;
  logic                  clk;
  logic                  rst_n;
  spl_pkg::spl_obj_req_t obj;
  spl_pkg::spl_pos_t     pos;
  logic [31:0]           rdata;
  logic                  rvalid;
  logic [3:0]            mode;
  logic [3:0]            period;
  logic [2:0]            csm;
  logic [2:0]            qs;
  logic                  abs_enc;
  logic                  hbusy;
  logic                  hdone;
  logic                  dirp;
  logic                  son;
  logic [15:0]           tq_obj;
  logic [31:0]           act;
  logic [31:0]           accel_eff;
  logic [15:0]           tq_int;
  logic                  st;
  logic                  qsr;
  logic                  blk_p;
  logic                  blk_n;
  logic                  fault;
  int                    errors;
  int                    n_tests;
  int                    i;
  logic [3:0]            mtab [5] = '{4'h1, 4'h7, 4'h8, 4'h3, 4'h6};
  logic                  etab [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [2:0]            qtab [4] = '{3'h2, 3'h6, 3'h1, 3'h0};

  spl_limit dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_obj(obj), .o_obj_rdata(rdata),
    .o_obj_rvalid(rvalid), .i_pos(pos), .i_op_mode(mode), .i_csm_state(csm),
    .i_abs_encoder(abs_enc), .i_homing_busy(hbusy), .i_homing_done(hdone),
    .i_servo_on(son), .i_torque_offset_obj(tq_obj), .i_qs_option(qs),
    .o_max_accel_eff(accel_eff), .o_torque_offset_int(tq_int), .o_status_limit_active(st),
    .o_quick_stop_req(qsr), .o_block_pos(blk_p), .o_block_neg(blk_n),
    .o_improper_op_fault(fault));

  spl_master_model master (.i_sys_clk(clk), .i_rst_n(rst_n), .i_period(period),
    .i_act(act), .i_cmd(act), .i_moving(1'b1), .i_dir_pos(dirp), .o_pos(pos));

  initial clk = 1'b0;
  always #4 clk = ~clk;

  // ---------------------------------------------------------------------------
  // Checking and access tasks
  // ---------------------------------------------------------------------------
  task automatic chk1(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk1

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk32

  task automatic obj_wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
    obj = '{wr: 1'b1, rd: 1'b0, index: idx, sub: sub, wdata: d};
    @(posedge clk);
    #1 obj = '0;
    @(posedge clk);
    #1;
  endtask : obj_wr

  // Read data is taken in the cycle after the request, where the valid pulse stands.
  task automatic obj_rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] e);
    obj = '{wr: 1'b0, rd: 1'b1, index: idx, sub: sub, wdata: 32'h0};
    @(posedge clk);
    #1 obj = '0;
    chk1(rvalid, 1'b1, "read valid");
    chk32(rdata, e, "read data");
    @(posedge clk);
    #1;
  endtask : obj_rd

  // Waits two strobes so the second one surely carries the new sample.
  task automatic step(input logic [31:0] a, input logic d);
    act  = a;
    dirp = d;
    repeat (2) begin
      @(posedge clk);
      while (pos.cycle !== 1'b1) @(posedge clk);
    end
    #1;
  endtask : step

  task automatic probe(input logic es, input logic eq);
    step(32'h0000_0032, 1'b1);
    step(32'h0000_0064, 1'b1);
    chk1(st, es, "limit status");
    chk1(qsr, eq, "quick stop");
  endtask : probe

  task automatic home_done();
    hdone = 1'b1;
    @(posedge clk);
    #1 hdone = 1'b0;
  endtask : home_done

  task automatic tdone(input string name);
    $display("test %s done", name);
  endtask : tdone

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  initial begin
    #200000;
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    rst_n   = 1'b0;
    obj     = '0;
    mode    = spl_pkg::MODE_PROFILE_POSITION;
    csm     = spl_pkg::CSM_PRE_OP;
    qs      = spl_pkg::QS_OPT_RAMP_A;
    abs_enc = 1'b1;
    hbusy   = 1'b0;
    hdone   = 1'b0;
    tq_obj  = 16'h1234;
    act     = 32'h0000_0000;
    dirp    = 1'b1;
    son     = 1'b0;
    period  = 4'h5;
    errors  = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    chk32(accel_eff, 32'h0000_0001, "floor at reset");
    obj_rd(16'h607D, 8'h00, 32'h0000_0002);
    obj_wr(16'h607D, 8'h00, 32'h0000_0005);
    obj_rd(16'h607D, 8'h00, 32'h0000_0002);
    obj_rd(16'h1234, 8'h00, 32'h0000_0000);
    obj_wr(16'h60C5, 8'h00, 32'hFFFF_FFFF);
    obj_rd(16'h60C5, 8'h00, 32'hFFFF_FFFF);
    chk32(accel_eff, 32'hFFFF_FFFF, "max accel");
    obj_wr(16'h60C5, 8'h00, 32'h0000_0000);
    chk32(accel_eff, 32'h0000_0001, "zero floor");
    obj_wr(16'h3724, 8'h00, 32'h0000_0080);
    repeat (2) @(posedge clk);
    #1 chk32({16'h0, tq_int}, 32'h0000_1234, "offset kept");
    obj_wr(16'h3724, 8'h00, 32'h0000_0000);
    repeat (2) @(posedge clk);
    #1 chk32({16'h0, tq_int}, 32'h0000_0000, "offset cleared");
    son = 1'b1;
    repeat (2) @(posedge clk);
    #1 chk32({16'h0, tq_int}, 32'h0000_1234, "offset at servo on");
    son = 1'b0;
    obj_wr(16'h607D, 8'h01, 32'hFFFF_FF9C);
    obj_wr(16'h607D, 8'h02, 32'h0000_0064);
    obj_rd(16'h607D, 8'h01, 32'hFFFF_FF9C);
    obj_rd(16'h607D, 8'h02, 32'h0000_0064);
    tdone("objects");
    for (i = 0; i < 5; i++) begin
      mode = mtab[i];
      probe(etab[i], etab[i]);
    end
    mode = spl_pkg::MODE_PROFILE_POSITION;
    for (i = 0; i < 4; i++) begin
      qs = qtab[i];
      probe(1'b1, i < 2);
    end
    qs = spl_pkg::QS_OPT_RAMP_B;
    chk1(blk_p, 1'b1, "block positive");
    chk1(blk_n, 1'b0, "free negative");
    step(32'hFFFF_FF9C, 1'b0);
    chk1(blk_n, 1'b1, "block negative");
    chk1(blk_p, 1'b0, "free positive");
    step(32'h0000_0096, 1'b1);
    step(32'h0000_0078, 1'b0);
    chk1(st, 1'b1, "still outside");
    step(32'h0000_0032, 1'b0);
    chk1(st, 1'b0, "back inside");
    tdone("modes");
    obj_wr(16'h607D, 8'h01, 32'h0000_0064);
    probe(1'b0, 1'b0);
    obj_wr(16'h607D, 8'h01, 32'h0000_0065);
    probe(1'b0, 1'b0);
    obj_wr(16'h607D, 8'h01, 32'hFFFF_FF9C);
    probe(1'b1, 1'b1);
    tdone("ordering");
    abs_enc = 1'b0;
    csm     = spl_pkg::CSM_INIT;
    repeat (3) @(posedge clk);
    #1 csm  = spl_pkg::CSM_PRE_OP;
    probe(1'b0, 1'b0);
    home_done();
    probe(1'b1, 1'b1);
    csm = spl_pkg::CSM_INIT;
    repeat (3) @(posedge clk);
    #1 csm  = spl_pkg::CSM_PRE_OP;
    probe(1'b0, 1'b0);
    abs_enc = 1'b1;
    probe(1'b1, 1'b1);
    csm = spl_pkg::CSM_INIT;
    probe(1'b0, 1'b0);
    csm   = spl_pkg::CSM_OP;
    hbusy = 1'b1;
    probe(1'b0, 1'b0);
    hbusy = 1'b0;
    probe(1'b0, 1'b0);
    home_done();
    probe(1'b1, 1'b1);
    tdone("coordinate");
    period = 4'h1;
    step(32'h0000_0000, 1'b1);
    chk1(fault, 1'b0, "no fault");
    step(32'h7FFF_FFF0, 1'b1);
    chk1(fault, 1'b1, "wrap fault");
    tdone("wrap");
    complete_run();
  end
endmodule : spl_limit_tb
